// file: pkg/toarc_pkg.sv
// Package with register map, field positions and timing for the overload autorange controller
package toarc_pkg;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] TOARC_REG_CTRL = 8'h00;
	localparam logic [7:0] TOARC_REG_STATUS = 8'h04;
	localparam logic [7:0] TOARC_REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] TOARC_REG_IRQ_MASK = 8'h0c;
	localparam logic [7:0] TOARC_REG_EVENT = 8'h10;

	// ************************************************************
	// Ranges and fields
	// ************************************************************
	localparam int TOARC_RANGE_W = 3;
	localparam logic [2:0] TOARC_RANGE_TOP = 3'h5;
	localparam logic [2:0] TOARC_RANGE_5V = 3'h3;
	localparam logic [2:0] TOARC_CTRL_RESET = 3'h0;
	localparam int TOARC_CTRL_EN_BIT = 8;
	localparam int TOARC_IRQ_RANGE = 0;
	localparam int TOARC_IRQ_GROUND = 1;
	localparam int TOARC_IRQ_POWER = 2;
	localparam int TOARC_IRQ_RESTORE = 3;
	localparam int TOARC_IRQ_W = 4;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int TOARC_CLK_MHZ = 25;
	localparam int TOARC_RESP_US = 1000;
	localparam int TOARC_RESP_CYC = TOARC_RESP_US * TOARC_CLK_MHZ;

	typedef enum logic [3:0] {
		TOARC_ST_NORMAL = 4'b0001,
		TOARC_ST_AUTO = 4'b0010,
		TOARC_ST_GROUND = 4'b0100,
		TOARC_ST_OFF = 4'b1000
	} toarc_state_t;

endpackage

// file: src/toarc_ctrl.sv
// Overload protection and thermal autorange controller with AHB-Lite registers
`timescale 1ns/10ps

// Summary of operation
// R1 - Below 200% overrange: no extra load, range left as user selected.
// R2 - Above 200% overrange: switch in the extra input current load first.
// R3 - Second action: in ranges up to 5 V, switch input stage away. The code sets it in the same cycle as the extra load.
// R4 - Each channel's own max-temperature flag alone triggers autoranging.
// R5 - Short overloads that never reach max temperature cause no range change.
// R6 - Each automatic step moves to the next range ten times less sensitive.
// R7 - If temperature persists after response time, step again by ten.
// R8 - Each automatic range change is marked in data stream with timestamp.
// R9 - Ground relay closes only in 1 kV range with temperature still hot.
// R10 - Critical temperature commands mains power off.
// R11 - User range is stored and restored once thermal conditions are normal.
// R12 - Persistent overload repeats escalation and restore alternately.
// R13 - Thermal flags arrive separately; range index saturates at top range.
module toarc_ctrl import toarc_pkg::*; #(
	parameter int RESP_CYC = TOARC_RESP_CYC
) (
	input wire logic i_clk, // 25 MHz clock
	input wire logic i_resetn, // Async reset, active low
	input wire logic i_hsel, // AHB select
	input wire logic [7:0] i_haddr, // AHB address
	input wire logic [1:0] i_htrans, // AHB transfer type
	input wire logic i_hwrite, // AHB write
	input wire logic [2:0] i_hsize, // AHB size
	input wire logic i_hready, // AHB ready in
	input wire logic [31:0] i_hwdata, // AHB write data
	output logic [31:0] o_hrdata, // AHB read data
	output logic o_hreadyout, // AHB ready out
	output logic o_hresp, // AHB response, always OKAY
	input wire logic i_over200, // Input above 200% of range (pin)
	input wire logic i_temp_max, // Local temperature at maximum (pin)
	input wire logic i_temp_crit, // Local temperature critical (pin)
	output logic [2:0] o_range, // Active range index
	output logic o_extra_load, // Extra current load enable
	output logic o_input_switch, // Input stage switch-away enable
	output logic o_ground_relay, // Ground relay closed
	output logic o_mains_off, // Mains power off command
	output logic o_range_mark, // Pulse: range changed in data stream
	output logic o_irq // Interrupt, level
);

	// Refuse a response time that the timer cannot count
	if (RESP_CYC < 1) begin : g_resp_check
		$error("RESP_CYC must be at least one");
	end

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [2:0] sync1;
	logic [2:0] sync2;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
		end else begin
			sync1 <= {i_temp_crit, i_temp_max, i_over200};
			sync2 <= sync1;
		end
	end
	logic over200;
	logic hot;
	logic crit;
	assign over200 = sync2[0];
	assign hot = sync2[1]; // R13
	assign crit = sync2[2]; // R13

	// ************************************************************
	// State
	// ************************************************************
	toarc_state_t state, next_state;
	logic [2:0] user_range, next_user_range;
	logic [2:0] range, next_range;
	logic enable, next_enable;
	logic [31:0] timer, next_timer;
	logic [31:0] tstamp, next_tstamp;
	logic [31:0] ev_stamp, next_ev_stamp;
	logic [3:0] irq_stat, next_irq_stat;
	logic [3:0] irq_mask, next_irq_mask;
	logic extra_load, next_extra_load;
	logic in_sw, next_in_sw;
	logic gnd, next_gnd;
	logic moff, next_moff;
	logic mark, next_mark;
	logic [3:0] ev;

	// Saturating range step by one decade
	function automatic logic [2:0] step_up(input logic [2:0] r);
		if (r >= TOARC_RANGE_TOP) begin
			return TOARC_RANGE_TOP; // R13
		end
		return r + 3'h1; // R6
	endfunction

	// ************************************************************
	// AHB-Lite slave
	// ************************************************************
	logic ap_wr, next_ap_wr;
	logic ap_rd, next_ap_rd;
	logic [7:0] ap_addr, next_ap_addr;
	logic [31:0] rdata, next_rdata;
	logic rd_clr;
	logic take;
	assign take = i_hsel && i_hready && i_htrans[1];

	// Address phase capture and read data mux
	always_comb begin
		next_ap_wr = take && i_hwrite;
		next_ap_rd = take && !i_hwrite;
		next_ap_addr = take ? i_haddr : ap_addr;
		next_rdata = 32'h0;
		rd_clr = 1'b0;
		if (take && !i_hwrite) begin
			case (i_haddr)
				TOARC_REG_CTRL: next_rdata = {23'h0, enable, 5'h0, user_range};
				TOARC_REG_STATUS: next_rdata = {20'h0, state, 1'b0, range, moff, gnd,
					in_sw, extra_load};
				TOARC_REG_IRQ_STAT: begin
					next_rdata = {28'h0, irq_stat};
					rd_clr = 1'b1;
				end
				TOARC_REG_IRQ_MASK: next_rdata = {28'h0, irq_mask};
				TOARC_REG_EVENT: next_rdata = ev_stamp;
				default: next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ap_wr <= 1'b0;
			ap_rd <= 1'b0;
			ap_addr <= 8'h0;
			rdata <= 32'h0;
		end else begin
			ap_wr <= next_ap_wr;
			ap_rd <= next_ap_rd;
			ap_addr <= next_ap_addr;
			rdata <= next_rdata;
		end
	end

	// ************************************************************
	// Protection sequencer
	// ************************************************************
	always_comb begin
		next_state = state;
		next_range = range;
		next_timer = timer;
		next_tstamp = tstamp + 32'h1;
		next_ev_stamp = ev_stamp;
		next_mark = 1'b0;
		next_user_range = user_range;
		next_enable = enable;
		next_irq_mask = irq_mask;
		ev = 4'h0;
		if (ap_wr && ap_addr == TOARC_REG_CTRL) begin
			next_user_range = (i_hwdata[2:0] > TOARC_RANGE_TOP) ? TOARC_RANGE_TOP
				: i_hwdata[2:0];
			next_enable = i_hwdata[TOARC_CTRL_EN_BIT];
		end
		if (ap_wr && ap_addr == TOARC_REG_IRQ_MASK) begin
			next_irq_mask = i_hwdata[3:0];
		end
		// Protective actions on overload
		next_extra_load = enable && over200; // R1 R2
		next_in_sw = enable && over200 && range <= TOARC_RANGE_5V; // R3
		next_gnd = gnd;
		next_moff = moff;
		if (enable && crit) begin
			next_moff = 1'b1; // R10
			next_state = TOARC_ST_OFF;
			if (!moff) begin
				ev[TOARC_IRQ_POWER] = 1'b1;
			end
		end else begin
			case (state)
				TOARC_ST_NORMAL: begin
					next_range = user_range; // R1 R11
					if (enable && hot) begin // R4 R5 R12
						next_timer = 32'h0;
						next_state = TOARC_ST_AUTO;
						// Already at the top range: no step, so nothing to mark
						if (range < TOARC_RANGE_TOP) begin
							next_range = step_up(range); // R6
							next_mark = 1'b1; // R8
							next_ev_stamp = tstamp;
							ev[TOARC_IRQ_RANGE] = 1'b1;
						end
					end
				end
				TOARC_ST_AUTO: begin
					if (!hot) begin
						next_range = user_range; // R11
						next_state = TOARC_ST_NORMAL;
						next_mark = 1'b1; // R8
						next_ev_stamp = tstamp;
						ev[TOARC_IRQ_RESTORE] = 1'b1;
					end else if (timer >= RESP_CYC - 1) begin
						next_timer = 32'h0;
						if (range == TOARC_RANGE_TOP) begin
							next_gnd = 1'b1; // R9
							next_state = TOARC_ST_GROUND;
							ev[TOARC_IRQ_GROUND] = 1'b1;
						end else begin
							next_range = step_up(range); // R7
							next_mark = 1'b1; // R8
							next_ev_stamp = tstamp;
							ev[TOARC_IRQ_RANGE] = 1'b1;
						end
					end else begin
						next_timer = timer + 32'h1;
					end
				end
				TOARC_ST_GROUND: begin
					if (!hot) begin
						next_gnd = 1'b0;
						next_range = user_range; // R11 R12
						next_state = TOARC_ST_NORMAL;
						next_mark = 1'b1; // R8
						next_ev_stamp = tstamp;
						ev[TOARC_IRQ_RESTORE] = 1'b1;
					end
				end
				TOARC_ST_OFF: begin
					// Latched until reset once power has been cut
				end
				default: next_state = TOARC_ST_NORMAL;
			endcase
		end
		// Sticky flags: set wins over read clear
		next_irq_stat = (rd_clr ? 4'h0 : irq_stat) | ev;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= TOARC_ST_NORMAL;
			range <= TOARC_CTRL_RESET;
			user_range <= TOARC_CTRL_RESET;
			enable <= 1'b1;
			timer <= 32'h0;
			tstamp <= 32'h0;
			ev_stamp <= 32'h0;
			irq_stat <= 4'h0;
			irq_mask <= 4'h0;
			extra_load <= 1'b0;
			in_sw <= 1'b0;
			gnd <= 1'b0;
			moff <= 1'b0;
			mark <= 1'b0;
		end else begin
			state <= next_state;
			range <= next_range;
			user_range <= next_user_range;
			enable <= next_enable;
			timer <= next_timer;
			tstamp <= next_tstamp;
			ev_stamp <= next_ev_stamp;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			extra_load <= next_extra_load;
			in_sw <= next_in_sw;
			gnd <= next_gnd;
			moff <= next_moff;
			mark <= next_mark;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	logic hreadyout;
	logic hresp;
	// Bus answer held in flops: zero wait states, always OKAY
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
	logic irq;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_irq_stat & next_irq_mask);
		end
	end

	assign o_hrdata = rdata;
	assign o_hreadyout = hreadyout;
	assign o_hresp = hresp;
	assign o_range = range;
	assign o_extra_load = extra_load;
	assign o_input_switch = in_sw;
	assign o_ground_relay = gnd;
	assign o_mains_off = moff;
	assign o_range_mark = mark;
	assign o_irq = irq;

endmodule // toarc_ctrl

// file: tb/toarc_ctrl_properties.sv
// Checker for the overload autorange controller ports
`timescale 1ns/10ps
module toarc_ctrl_properties import toarc_pkg::*; (
	input wire logic i_clk, // Clock
	input wire logic i_resetn, // Reset, active low
	input wire logic i_over200, // Overrange pin
	input wire logic i_temp_max, // Hot pin
	input wire logic i_temp_crit, // Critical pin
	input wire logic [2:0] o_range, // Active range
	input wire logic o_extra_load, // Extra load
	input wire logic o_input_switch, // Switch-away
	input wire logic o_ground_relay, // Ground relay
	input wire logic o_mains_off, // Mains off
	input wire logic o_range_mark // Range mark
);
	// ****************************************
	// Sequences and assertions
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// Automatic step upwards, and ground closing
	sequence s_step;
		o_range_mark && (o_range > $past(o_range));
	endsequence
	sequence s_gnd;
		$rose(o_ground_relay);
	endsequence
	AST_STEP: assert property (s_step |-> $past(i_temp_max, 3)
		&& (o_range == $past(o_range) + 3'h1)) else $error("bad range step");
	AST_MARK: assert property (o_range_mark |=> !o_range_mark)
		else $error("mark not a pulse");
	AST_SAT: assert property (o_range <= TOARC_RANGE_TOP) else $error("range wrap");
	AST_GND: assert property (s_gnd |-> (o_range == TOARC_RANGE_TOP)
		&& $past(i_temp_max, 3)) else $error("ground too early");
	AST_CRIT: assert property ($rose(i_temp_crit) |-> ##[1:3] o_mains_off)
		else $error("no mains off");
	AST_LATCH: assert property (o_mains_off |=> o_mains_off) else $error("mains off lost");
	AST_LOAD: assert property ($rose(o_extra_load) |-> $past(i_over200, 3))
		else $error("load without overrange");
	AST_NOLOAD: assert property (!$past(i_over200, 3) |-> !o_extra_load)
		else $error("load while in range");
	AST_SWITCH: assert property (o_input_switch |-> (o_range <= TOARC_RANGE_5V)
		|| ($past(o_range) <= TOARC_RANGE_5V)) else $error("switch in high range");
endmodule // toarc_ctrl_properties
bind toarc_ctrl toarc_ctrl_properties u_toarc_ctrl_properties (.*);

// file: tb/toarc_front.sv
// Model of the front end, overrange detector and thermal sensor
`timescale 1ns/10ps
module toarc_front (
	input wire logic i_clk, // Clock
	input wire logic [2:0] i_range, // Active range
	input wire logic i_ground, // Ground relay closed
	input wire logic i_load, // Overload applied
	input wire logic [2:0] i_safe, // Range at which heating stops
	input wire logic i_crit, // Fault heating
	output logic o_over200, // Overrange flag
	output logic o_temp_max, // Hot flag
	output logic o_temp_crit // Critical flag
);
	initial {o_over200, o_temp_max, o_temp_crit} = 3'h0;
	// Grounded input sees no overload; heat stops once range is high enough
	always @(posedge i_clk) begin
		o_over200 <= i_load && !i_ground;
		o_temp_max <= i_load && !i_ground && (i_range < i_safe);
		o_temp_crit <= i_crit;
	end
endmodule // toarc_front

// file: tb/tb.sv
// Testbench for the overload autorange controller
`timescale 1ns/10ps
module tb import toarc_pkg::*;;
	logic i_clk = 0, i_resetn = 0, i_hsel = 0, i_hwrite = 0, i_hready;
	logic [7:0] i_haddr = 8'h00;
	logic [1:0] i_htrans = 2'h0;
	logic [2:0] i_hsize = 3'h2, safe = 3'h0;
	logic [31:0] i_hwdata = 32'h0, o_hrdata, rd;
	logic o_hreadyout, o_hresp, i_over200, i_temp_max, i_temp_crit, load = 0, crit = 0;
	logic [2:0] o_range;
	logic o_extra_load, o_input_switch, o_ground_relay, o_mains_off, o_range_mark, o_irq;
	int fails = 0, total_checks = 0;
	int cyc = 0, mark_at = 0;
	assign i_hready = o_hreadyout;
	always #20 i_clk = ~i_clk;
	// Cycles since reset, and the stamp that the latest range mark should carry
	always @(posedge i_clk) begin
		if (i_resetn) begin
			cyc <= cyc + 1;
		end
		if (o_range_mark) begin
			mark_at <= cyc - 1;
		end
	end
	toarc_ctrl #(.RESP_CYC(8)) u_toarc_ctrl (.*);
	toarc_front u_toarc_front (.i_clk(i_clk), .i_range(o_range), .i_ground(o_ground_relay),
		.i_load(load), .i_safe(safe), .i_crit(crit), .o_over200(i_over200),
		.o_temp_max(i_temp_max), .o_temp_crit(i_temp_crit));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	// Single AHB transfer, request held until hready sampled high
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_hsel <= 1;
		i_htrans <= 2'h2;
		i_haddr <= a;
		i_hwrite <= w;
		do @(posedge i_clk); while (o_hreadyout !== 1'b1);
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(posedge i_clk); while (o_hreadyout !== 1'b1);
		rd = o_hrdata;
		chk("hresp", 32'h0, {31'h0, o_hresp});
	endtask
	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		ahb(0, a, 32'h0);
		chk(n, e, rd);
	endtask
	task automatic waitr(input logic [2:0] v);
		for (int i = 0; i < 200 && o_range !== v; i++) @(posedge i_clk);
		chk("range", {29'h0, v}, {29'h0, o_range});
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#400000;
		fails++;
		results;
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (16) @(posedge i_clk);
		i_resetn <= 1;
		rdchk("ctrl", TOARC_REG_CTRL, 32'h100);
		rdchk("status", TOARC_REG_STATUS, 32'h100);
		rdchk("mask", TOARC_REG_IRQ_MASK, 32'h0);
		rdchk("unmapped", 8'h14, 32'h0);
		ahb(1, TOARC_REG_CTRL, 32'h100);
		safe <= 3'h2;
		load <= 1;
		waitr(3'h1);
		waitr(3'h2);
		waitr(3'h0);
		waitr(3'h1);
		load <= 0;
		waitr(3'h0);
		chk("irq masked", 0, o_irq);
		ahb(1, TOARC_REG_IRQ_MASK, 32'hf);
		repeat (2) @(posedge i_clk);
		chk("irq", 1, o_irq);
		rdchk("irq stat", TOARC_REG_IRQ_STAT, 32'h9);
		rdchk("irq clr", TOARC_REG_IRQ_STAT, 32'h0);
		chk("irq off", 0, o_irq);
		ahb(1, TOARC_REG_CTRL, 32'h103);
		safe <= 3'h0;
		load <= 1;
		repeat (8) @(posedge i_clk);
		chk("load", 1, o_extra_load);
		chk("switch", 1, o_input_switch);
		rdchk("status", TOARC_REG_STATUS, 32'h133);
		safe <= 3'h6;
		waitr(3'h4);
		for (int i = 0; i < 300 && o_ground_relay !== 1'b1; i++) @(posedge i_clk);
		chk("ground", 1, o_ground_relay);
		chk("top", 32'h5, {29'h0, o_range});
		load <= 0;
		waitr(3'h3);
		ahb(1, TOARC_REG_CTRL, 32'h003);
		load <= 1;
		repeat (10) @(posedge i_clk);
		chk("off range", 32'h3, {29'h0, o_range});
		chk("off load", 0, o_extra_load);
		ahb(1, TOARC_REG_CTRL, 32'h103);
		crit <= 1;
		repeat (5) @(posedge i_clk);
		chk("mains", 1, o_mains_off);
		rdchk("status off", TOARC_REG_STATUS, 32'h849);
		rdchk("irq all", TOARC_REG_IRQ_STAT, 32'hf);
		rdchk("event", TOARC_REG_EVENT, mark_at);
		results;
	end
endmodule // tb
